// file: hw/dcl_device.sv
// device end: frame decode, clear value, control and pulse logic
// assumes frames arrive as one-cycle strobes and pins are synchronous
// pin levels act on every cycle they are low; bits act only once
// when clear and load are both asked for, clear wins, except that a clear bit is dropped while the load pin is low
`timescale 1ns/10ps
module dcl_device (
  input wire logic i_clock,
  input wire logic i_resetn,
  dcl_link_if.device link,
  output logic [dcl_pkg::DATA_W-1:0] o_dac_code,
  output dcl_pkg::dcl_out_e o_out_state,
  output logic o_out_drive,
  output logic o_out_tristate,
  output logic o_out_ground,
  output logic o_fb_parallel,
  output logic o_code_format,
  output logic [dcl_pkg::LIN_W-1:0] o_lin_trim
);
  import dcl_pkg::*;

  dcl_dev_s st_r;
  dcl_dev_s st_nxt;
  logic wr_frame;
  logic rd_frame;
  logic [2:0] addr;
  logic [DATA_W-1:0] data;
  logic wr_dac;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_pulse;
  logic ctl_float;
  logic ctl_clamp;
  logic ctl_fb;
  logic ctl_fmt;
  logic [LIN_W-1:0] ctl_lin;
  logic bit_load;
  logic bit_clear;
  logic bit_reset;
  logic soft_load;
  logic soft_clear;
  logic soft_reset;
  logic clr_pin;
  logic ld_pin;
  logic clear_now;
  logic load_now;
  logic [FRAME_W-1:0] rd_word;

  // frame field split
  assign wr_frame = link.frame_valid & ~link.frame[RW_BIT];
  assign rd_frame = link.frame_valid & link.frame[RW_BIT];
  assign addr = link.frame[ADDR_HI:ADDR_LO];
  assign data = link.frame[DATA_HI:DATA_LO];
  assign clr_pin = ~link.clear_input_n;
  assign ld_pin = ~link.load_update_input_n;

  // one write strobe per register address
  assign wr_dac = wr_frame & (addr == ADDR_DAC);
  assign wr_ctrl = wr_frame & (addr == ADDR_CTRL);
  assign wr_clear = wr_frame & (addr == ADDR_CLEAR);
  assign wr_pulse = wr_frame & (addr == ADDR_SOFT);

  // control word fields; bits outside these are ignored
  assign ctl_float = link.frame[CTL_FLOAT_BIT];
  assign ctl_clamp = link.frame[CTL_GND_BIT];
  assign ctl_fb = link.frame[CTL_FB_BIT];
  assign ctl_fmt = link.frame[CTL_FMT_BIT];
  assign ctl_lin = link.frame[CTL_LIN_LO+LIN_W-1:CTL_LIN_LO];

  // pulse word function bits; the reserved bits are never read
  assign bit_load = link.frame[SOFT_LOAD_BIT];
  assign bit_clear = link.frame[SOFT_CLEAR_BIT];
  assign bit_reset = link.frame[SOFT_RESET_BIT];

  // pulse decode; only the three low bits mean anything
  always_comb begin
    soft_load = 1'b0;
    soft_clear = 1'b0;
    soft_reset = 1'b0;
    if (wr_pulse) begin
      soft_load = bit_load & ~clr_pin;
      soft_clear = bit_clear & ~ld_pin;
      soft_reset = bit_reset;
    end
  end

  // pin and bit requests merged; a bit acts as a one-cycle pin pulse, save that a clear bit is dropped while the load pin is low
  assign clear_now = clr_pin | soft_clear;
  assign load_now = ld_pin | soft_load;

  // read answer word: flag, address, then the register contents
  always_comb begin
    rd_word = {1'b1, addr, 20'h00000};
    case (addr)
      ADDR_DAC: begin
        rd_word[DATA_HI:DATA_LO] = st_r.dac_code;
      end
      ADDR_CTRL: begin
        rd_word[CTL_FLOAT_BIT] = st_r.out_float;
        rd_word[CTL_GND_BIT] = st_r.gnd_clamp;
        rd_word[CTL_FB_BIT] = st_r.fb_mode;
        rd_word[CTL_FMT_BIT] = st_r.code_fmt;
        rd_word[CTL_LIN_LO+LIN_W-1:CTL_LIN_LO] = st_r.lin_trim;
      end
      ADDR_CLEAR: begin
        rd_word[DATA_HI:DATA_LO] = st_r.clear_code;
      end
      default: ; // write-only pulse register reads as zero
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    // register writes
    // input code waits here until a load pin or bit moves it on
    if (wr_dac) begin
      st_nxt.input_code = data;
    end
    if (wr_ctrl) begin
      // float and clamp leave power-on state only here
      st_nxt.out_float = ctl_float;
      st_nxt.gnd_clamp = ctl_clamp;
      st_nxt.fb_mode = ctl_fb;
      st_nxt.code_fmt = ctl_fmt;
      st_nxt.lin_trim = ctl_lin;
    end
    // pulse register stores nothing; its bits act only in their frame
    if (wr_clear) begin
      st_nxt.clear_code = data;
    end
    // dac register update: clear has priority over load
    // a clear value written in the same cycle applies next time
    if (clear_now) begin
      st_nxt.dac_code = st_r.clear_code;
    end else if (load_now) begin
      st_nxt.dac_code = st_nxt.input_code;
    end
    // read answer one cycle after the frame
    // rdata keeps its last answer until the next read frame or a soft reset
    if (rd_frame) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
    end
    // code at the converter: twos complement flips the top bit
    // registered, so the converter never sees a half-updated code
    st_nxt.out_code = st_nxt.dac_code;
    if (!st_nxt.code_fmt) begin
      st_nxt.out_code[DATA_W-1] = ~st_nxt.dac_code[DATA_W-1];
    end
    // soft reset behaves exactly as power-on
    if (soft_reset) begin
      st_nxt = DEV_RST;
    end
  end

  // state register; reset gives all power-on defaults
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= DEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // output condition decode
  dcl_out_state u_out (
    .i_float(st_r.out_float),
    .i_clamp(st_r.gnd_clamp),
    .o_state(o_out_state),
    .o_drive(o_out_drive),
    .o_tristate(o_out_tristate),
    .o_ground(o_out_ground)
  );

  // analog code comes straight from its own register
  assign o_dac_code = st_r.out_code;

  // plain register outputs
  assign o_fb_parallel = st_r.fb_mode;
  assign o_code_format = st_r.code_fmt;
  assign o_lin_trim = st_r.lin_trim;
  assign link.rdata = st_r.rdata;
  assign link.rvalid = st_r.rvalid;
endmodule

// file: hw/dcl_host.sv
// host end: apb registers turned into frames and pin levels
// assumes a zero-wait apb master on the same clock
`timescale 1ns/10ps
module dcl_host (
  input wire logic i_clock,
  input wire logic i_resetn,
  dcl_link_if.host link,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import dcl_pkg::*;

  dcl_host_s st_r;
  dcl_host_s st_nxt;
  logic acc;
  logic mapped;

  // access phase and address check
  assign acc = i_psel & i_penable;
  assign mapped = (i_paddr == APB_FRAME) || (i_paddr == APB_PINS) ||
                  (i_paddr == APB_RDBK) || (i_paddr == APB_STAT);
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~mapped;

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.frame_valid = 1'b0;
    // answer from the device; arrival wins over a clearing read
    if (acc && !i_pwrite && i_paddr == APB_RDBK) begin
      st_nxt.rdbk_valid = 1'b0;
    end
    if (link.rvalid) begin
      st_nxt.rdbk = link.rdata;
      st_nxt.rdbk_valid = 1'b1;
      st_nxt.pend = 1'b0;
    end
    if (acc && i_pwrite) begin
      case (i_paddr)
        APB_FRAME: begin
          // frame goes out exactly as written, reserved pulse bits included
          st_nxt.frame = i_pwdata[FRAME_W-1:0];
          st_nxt.frame_valid = 1'b1;
          st_nxt.pend = i_pwdata[RW_BIT];
        end
        APB_PINS: begin
          st_nxt.clear_n = ~i_pwdata[PIN_CLEAR_BIT];
          st_nxt.load_n = ~i_pwdata[PIN_LOAD_BIT];
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= HOST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read mux of register contents
  always_comb begin
    o_prdata = 32'h00000000;
    case (i_paddr)
      APB_FRAME: o_prdata = {8'h00, st_r.frame};
      APB_PINS: o_prdata = {30'h00000000, ~st_r.load_n, ~st_r.clear_n};
      APB_RDBK: o_prdata = {7'h00, st_r.rdbk_valid, st_r.rdbk};
      APB_STAT: o_prdata = {31'h00000000, st_r.pend};
      default: o_prdata = 32'h00000000;
    endcase
  end

  // link drive
  assign link.frame_valid = st_r.frame_valid;
  assign link.frame = st_r.frame;
  assign link.clear_input_n = st_r.clear_n;
  assign link.load_update_input_n = st_r.load_n;
endmodule

// file: hw/dcl_link_if.sv
// link between host end and device end: frame strobe, two pins and the read answer
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface dcl_link_if;
  import dcl_pkg::*;
  logic frame_valid;
  logic [FRAME_W-1:0] frame;
  logic clear_input_n;
  logic load_update_input_n;
  logic [FRAME_W-1:0] rdata;
  logic rvalid;

  modport device (
    input frame_valid, frame, clear_input_n, load_update_input_n,
    output rdata, rvalid
  );
  modport host (
    output frame_valid, frame, clear_input_n, load_update_input_n,
    input rdata, rvalid
  );
endinterface

// file: hw/dcl_out_state.sv
// decodes the float and clamp bits into the output condition
// assumes registered inputs from the device state
`timescale 1ns/10ps
module dcl_out_state (
  input wire logic i_float,
  input wire logic i_clamp,
  output dcl_pkg::dcl_out_e o_state,
  output logic o_drive,
  output logic o_tristate,
  output logic o_ground
);
  import dcl_pkg::*;

  // clamp overrides float whatever its value
  always_comb begin
    case ({i_clamp, i_float})
      2'b00: o_state = OUT_NORMAL;
      2'b01: o_state = OUT_FLOAT;
      default: o_state = OUT_CLAMP;
    endcase
  end

  // one line per condition
  assign o_drive = (o_state == OUT_NORMAL);
  assign o_tristate = (o_state == OUT_FLOAT);
  assign o_ground = (o_state == OUT_CLAMP);
endmodule

// file: hw/dcl_pkg.sv
// shared constants and types for the dac clear/load control pair
// assumes one 100 MHz clock shared by host end and device end
package dcl_pkg;

  // frame layout: rw flag, address field, 18-bit data field
  localparam int FRAME_W = 24;
  localparam int DATA_W = 18;
  localparam int LIN_W = 4;
  localparam int RW_BIT = 23;
  localparam int ADDR_HI = 22;
  localparam int ADDR_LO = 20;
  localparam int DATA_HI = 19;
  localparam int DATA_LO = 2;

  // register addresses carried in the frame
  localparam logic [2:0] ADDR_DAC = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_CLEAR = 3'h3;
  localparam logic [2:0] ADDR_SOFT = 3'h4;

  // software pulse control bits
  localparam int SOFT_LOAD_BIT = 0;
  localparam int SOFT_CLEAR_BIT = 1;
  localparam int SOFT_RESET_BIT = 2;

  // control register field positions
  localparam int CTL_FB_BIT = 1;
  localparam int CTL_GND_BIT = 2;
  localparam int CTL_FLOAT_BIT = 3;
  localparam int CTL_FMT_BIT = 4;
  localparam int CTL_LIN_LO = 6;

  // values after reset
  localparam logic FLOAT_RST = 1'b1;
  localparam logic GND_RST = 1'b1;
  localparam logic FB_RST = 1'b1;
  localparam logic FMT_RST = 1'b0;
  localparam logic [LIN_W-1:0] LIN_RST = 4'h0;
  localparam logic [LIN_W-1:0] LIN_20V = 4'hC;
  localparam logic [DATA_W-1:0] CLEAR_RST = 18'h00000;
  // negative reference code in twos complement
  localparam logic [DATA_W-1:0] DAC_RST = 18'h20000;
  // same code as seen at the converter, offset binary
  localparam logic [DATA_W-1:0] OUT_CODE_RST = 18'h00000;

  // host apb map
  localparam logic [7:0] APB_FRAME = 8'h00;
  localparam logic [7:0] APB_PINS = 8'h04;
  localparam logic [7:0] APB_RDBK = 8'h08;
  localparam logic [7:0] APB_STAT = 8'h0C;
  localparam int PIN_CLEAR_BIT = 0;
  localparam int PIN_LOAD_BIT = 1;
  localparam int RDBK_VALID_BIT = 24;

  // output condition, one-hot
  typedef enum logic [2:0] {
    OUT_NORMAL = 3'b001,
    OUT_FLOAT = 3'b010,
    OUT_CLAMP = 3'b100
  } dcl_out_e;

  // whole device state
  typedef struct packed {
    logic out_float;
    logic gnd_clamp;
    logic fb_mode;
    logic code_fmt;
    logic [LIN_W-1:0] lin_trim;
    logic [DATA_W-1:0] input_code;
    logic [DATA_W-1:0] dac_code;
    logic [DATA_W-1:0] clear_code;
    logic [DATA_W-1:0] out_code;
    logic [FRAME_W-1:0] rdata;
    logic rvalid;
  } dcl_dev_s;

  localparam dcl_dev_s DEV_RST = '{
    out_float: FLOAT_RST, gnd_clamp: GND_RST, fb_mode: FB_RST,
    code_fmt: FMT_RST, lin_trim: LIN_RST, input_code: DAC_RST,
    dac_code: DAC_RST, clear_code: CLEAR_RST, out_code: OUT_CODE_RST,
    rdata: 24'h000000, rvalid: 1'b0};

  // whole host state
  typedef struct packed {
    logic frame_valid;
    logic [FRAME_W-1:0] frame;
    logic clear_n;
    logic load_n;
    logic [FRAME_W-1:0] rdbk;
    logic rdbk_valid;
    logic pend;
  } dcl_host_s;

  localparam dcl_host_s HOST_RST = '{
    frame_valid: 1'b0, frame: 24'h000000, clear_n: 1'b1, load_n: 1'b1,
    rdbk: 24'h000000, rdbk_valid: 1'b0, pend: 1'b0};

endpackage

// file: testbench/dcl_properties.sv
// checker on the link and device outputs of the dac control pair
// assumes instantiation beside the link interface in the bench
`timescale 1ns/10ps
module dcl_properties
  import dcl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic frame_valid,
  input wire logic [FRAME_W-1:0] frame,
  input wire logic clear_input_n,
  input wire logic load_update_input_n,
  input wire logic [FRAME_W-1:0] rdata,
  input wire logic rvalid,
  input wire logic [DATA_W-1:0] o_dac_code,
  input dcl_out_e o_out_state,
  input wire logic o_code_format
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic ctl_w;
  logic soft_rst;
  // frame decode helpers
  assign ctl_w = frame_valid && frame[23:20] == 4'h2;
  assign soft_rst = frame_valid && frame[23:20] == 4'h4 && frame[2];

  a_strobe_single: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe longer than one cycle");
  a_read_answer: assert property (frame_valid && frame[23] |=> rvalid &&
    rdata[23] && rdata[22:20] == $past(frame[22:20]))
    else $error("read frame not answered");
  a_answer_cause: assert property (rvalid |-> $past(frame_valid) &&
    $past(frame[23])) else $error("answer without read frame");
  a_soft_reset: assert property (soft_rst && clear_input_n |=>
    o_out_state == OUT_CLAMP && o_dac_code == 18'h00000 && !o_code_format)
    else $error("soft reset did not restore defaults");
  a_state_decode: assert property (ctl_w |=> o_out_state ==
    ($past(frame[2]) ? OUT_CLAMP : ($past(frame[3]) ? OUT_FLOAT : OUT_NORMAL)))
    else $error("output state decode wrong");
  a_format_write: assert property (ctl_w |=>
    o_code_format == $past(frame[4])) else $error("code format not written");
  a_state_hold: assert property (!$stable(o_out_state) |->
    $past(ctl_w) || $past(soft_rst)) else $error("output state moved alone");
  a_dac_cause: assert property (!$stable(o_dac_code) |-> $past(frame_valid)
    || !$past(clear_input_n) || !$past(load_update_input_n))
    else $error("dac code moved without cause");
endmodule

// file: testbench/tb_dac_clear_load_control.sv
// self-checking bench: host end and device end joined by the link
// assumes package, interface, both ends and the checker compiled first
`timescale 1ns/10ps
module tb_dac_clear_load_control;
  import dcl_pkg::*;
  logic i_clock, i_resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, x;
  logic [17:0] dac_code;
  dcl_out_e out_state;
  logic drv, tri_o, gnd_o, fbp, fmt_o;
  logic [3:0] lin_o;
  int bad_count, compares, cyc, clr, inp, dac, fmt, flt, gnd, fb, lin;

  dcl_link_if link();
  dcl_host dcl_host_inst(.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link.host), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  dcl_device dcl_device_inst(.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link.device), .o_dac_code(dac_code), .o_out_state(out_state),
    .o_out_drive(drv), .o_out_tristate(tri_o), .o_out_ground(gnd_o),
    .o_fb_parallel(fbp), .o_code_format(fmt_o), .o_lin_trim(lin_o));
  dcl_properties dcl_properties_inst(.i_clock(i_clock),
    .i_resetn(i_resetn), .frame_valid(link.frame_valid),
    .frame(link.frame), .clear_input_n(link.clear_input_n),
    .load_update_input_n(link.load_update_input_n), .rdata(link.rdata),
    .rvalid(link.rvalid), .o_dac_code(dac_code),
    .o_out_state(out_state), .o_code_format(fmt_o));

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic rdy;
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      rdy = pready;
      rd = prdata;
      err = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // frame sent, checked on the wire, effect settled on return
  task automatic send(input logic [23:0] f);
    apb(1'b1, APB_FRAME, {8'h00, f});
    #1;
    chk(link.frame_valid, 1'b1);
    chk(link.frame, f);
    @(posedge i_clock);
    #1;
  endtask

  // device outputs against the model
  task automatic look();
    logic [17:0] d;
    d = dac[17:0];
    chk(dac_code, fmt ? d : d ^ 18'h20000);
    chk(out_state, gnd ? OUT_CLAMP : (flt ? OUT_FLOAT : OUT_NORMAL));
    chk({gnd_o, tri_o, drv}, gnd ? 4 : (flt ? 2 : 1));
    chk(fbp, fb);
    chk(fmt_o, fmt);
    chk(lin_o, lin);
  endtask

  task automatic ctl(input int fl, input int g, input int f, input int m,
                     input int l);
    flt = fl;
    gnd = g;
    fb = f;
    fmt = m;
    lin = l;
    send({4'h2, 10'h000, l[3:0], 1'b0, m[0], fl[0], g[0], f[0], 1'b0});
    look();
  endtask

  task automatic rdback(input logic [3:0] a, input int e);
    send({a, 20'h00000});
    repeat (2) @(posedge i_clock);
    apb(1'b0, APB_RDBK, 32'h0);
    chk(rd[24], 1'b1);
    chk(rd[19:2], e[17:0]);
    apb(1'b0, APB_RDBK, 32'h0);
    chk(rd[24], 1'b0);
    apb(1'b0, APB_STAT, 32'h0);
    chk(rd[0], 1'b0);
  endtask

  task automatic dflt();
    clr = 0;
    inp = 32'h20000;
    dac = inp;
    fmt = 0;
    flt = 1;
    gnd = 1;
    fb = 1;
    lin = 0;
    #1;
    look();
  endtask

  // clock and timeout
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    {i_resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h36;
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    dflt();
    rdback(4'hB, 0);
    for (int i = 0; i < 4; i++) ctl(i % 2, i / 2, 1, 0, 0);
    ctl(0, 0, 0, 0, 12);
    ctl(0, 0, 1, 0, 0);
    for (int i = 0; i < 4; i++) begin
      clr = rnd() & 32'h3FFFF;
      send({4'h3, clr[17:0], 2'b11});
      rdback(4'hB, clr);
      inp = rnd() & 32'h3FFFF;
      send({4'h1, inp[17:0], 2'b00});
      look();
      ctl(0, 0, 1, i % 2, 0);
      send(24'h400001);
      dac = inp;
      look();
      send(24'h400002);
      dac = clr;
      look();
    end
    send(24'h400001);
    dac = inp;
    look();
    apb(1'b1, APB_PINS, 32'h1);
    repeat (2) @(posedge i_clock);
    #1;
    dac = clr;
    look();
    apb(1'b0, APB_PINS, 32'h0);
    chk(rd[1:0], 2'b01);
    inp = rnd() & 32'h3FFFF;
    send({4'h1, inp[17:0], 2'b00});
    send(24'h400001);
    look();
    apb(1'b1, APB_PINS, 32'h2);
    repeat (2) @(posedge i_clock);
    #1;
    dac = inp;
    look();
    send(24'h400002);
    look();
    apb(1'b1, APB_PINS, 32'h0);
    x = rnd();
    send({4'h4, x[19:3], 3'b000});
    look();
    apb(1'b1, 8'h10, 32'h400002);
    chk(err, 1'b1);
    rdback(4'hC, 0);
    ctl(0, 0, 0, 1, 12);
    send(24'h400004);
    dflt();
    rdback(4'hB, 0);
    stop_test();
  end
endmodule
